// File: rtl/conv_ctrl.sv
// Purpose: converter switch sequencing, pass-through control, supply irq enables
// Assumes: comparator inputs synchronous to clk; register port is byte-wide
// Notes:   analog stage, regulators and voltage table live elsewhere
`timescale 1ns/100ps
`default_nettype none
module conv_ctrl
    import conv_pkg::*;
#(
    parameter int DWELL_COUNT = conv_pkg::DWELL_CYC,
    parameter int ENTRY_COUNT = conv_pkg::ENTRY_CYC
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire conv_pkg::opmode_e opmode,
    input  wire logic             reg_wr,
    input  wire logic             reg_rd,
    input  wire logic [7:0]       reg_addr,
    input  wire logic [7:0]       reg_wdata,
    output logic      [7:0]       reg_rdata,
    input  wire logic             in_above_out,
    input  wire logic             in_near_out,
    input  wire logic             in_under,
    input  wire logic             in_over,
    input  wire logic             overtemp_warn,
    input  wire logic             overcurrent,
    input  wire logic             out_in_window,
    input  wire logic             out_above_set,
    input  wire logic             boot_low,
    output logic                  sw_s1,
    output logic                  sw_s2,
    output logic                  sw_s3,
    output logic                  sw_s4,
    output logic                  conv_on,
    output logic                  passthru_active,
    output logic      [3:0]       conv_voltage_code,
    output logic                  conv_thermal_derate,
    output logic                  conv_status_irq
);
    import conv_pkg::*;

    typedef enum logic [2:0] {PT_SWITCH, PT_RAMP, PT_HOLD, PT_SETTLE} pt_state_e;

    function automatic logic onoff_runs(input logic [1:0] c, input opmode_e m);
        onoff_runs = (c == ONOFF_PASSTHRU) || (m != OPM_SLEEP) || (c == 2'h1);
    endfunction

    logic [1:0] conv_onoff_ctrl_q;
    logic [3:0] conv_voltage_code_q;
    logic       conv_thermal_derate_q;
    logic       conv_status_flag_q, conv_status_irq_flag_q;
    logic [5:0] irq_en_q;
    opmode_e    mode_q;
    pt_state_e  pt_q;
    logic [5:0] pwm_q;
    logic [4:0] period_cnt_q;
    logic       boot_slot_q;
    logic [5:0] duty_q;
    logic [5:0] ss_limit_q;
    logic [7:0] ramp_div_q;
    logic [7:0] rdata_q;
    logic       s1_q, s2_q, s3_q, s4_q, on_q, pt_out_q, irq_q;
    logic [3:0] code_eff_q;

    conv_timer_if dwell_if();
    conv_timer_if entry_if();
    conv_dwell_timer #(.COUNT(DWELL_COUNT)) u_dwell (.clk(clk), .rst(rst), .tif(dwell_if));
    conv_dwell_timer #(.COUNT(ENTRY_COUNT)) u_entry (.clk(clk), .rst(rst), .tif(entry_if));

    // mode decode
    wire mode_change  = (opmode != mode_q);
    wire forced_norm  = (opmode == OPM_FORCED_NORMAL);
    wire user_mode    = (opmode == OPM_STANDBY) || (opmode == OPM_NORMAL) ||
                        (opmode == OPM_SLEEP);
    wire fixed_mode   = (opmode == OPM_OFF) || (opmode == OPM_RESET) ||
                        (opmode == OPM_OVERLOAD) || (opmode == OPM_FAIL_SAFE);
    wire fixed_on     = (opmode == OPM_RESET) || (opmode == OPM_FAIL_SAFE) ||
                        forced_norm;
    wire conv_run     = user_mode ? onoff_runs(conv_onoff_ctrl_q, opmode)
                                  : fixed_on;
    wire pt_request   = user_mode && (conv_onoff_ctrl_q == ONOFF_PASSTHRU);
    wire in_ok        = !in_under && !in_over;
    // overcurrent cannot be seen while switching; it only counts once holding
    wire pt_enter_ok  = pt_request && in_ok;
    wire pt_ramp_exit = !pt_request || !in_ok || overtemp_warn;
    wire pt_exit      = !pt_request || !in_ok || overtemp_warn || overcurrent;

    // register decode; converter registers hidden in forced-normal
    wire wr_ok        = reg_wr && !forced_norm;
    wire wr_ctrl      = wr_ok && (reg_addr == CONV_CTRL_ADDR);
    wire wr_volt      = wr_ok && (reg_addr == CONV_VOLT_ADDR);
    wire wr_en        = wr_ok && (reg_addr == SUPPLY_IRQ_EN_ADDR);
    wire wr_stat      = wr_ok && (reg_addr == SUPPLY_IRQ_STAT_ADDR);

    logic [7:0] rd_mux;
    always_comb begin
        rd_mux = 8'h00;
        if (!forced_norm) begin
            case (reg_addr)
                CONV_CTRL_ADDR:       rd_mux = {4'h0, conv_thermal_derate_q, 1'b0,
                                                conv_onoff_ctrl_q};
                CONV_VOLT_ADDR:       rd_mux = {4'h0, conv_voltage_code_q};
                SUPPLY_IRQ_EN_ADDR:   rd_mux = {2'b00, irq_en_q};
                SUPPLY_IRQ_STAT_ADDR: rd_mux = {2'b00, conv_status_irq_flag_q, 5'h00};
                default:              rd_mux = 8'h00;
            endcase
        end
    end

    // status flag: in window and not in pass-through
    wire status_now   = out_in_window && (pt_q == PT_SWITCH) && conv_run;
    wire status_chg   = status_now != conv_status_flag_q;
    wire stat_clr     = wr_stat && reg_wdata[IRQ_EN_CONV_BIT];

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mode_q <= OPM_OFF;
        end else begin
            mode_q <= opmode;
        end
    end

    // control/config registers with per-mode reload
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            conv_onoff_ctrl_q     <= ONOFF_DEFAULT;
            conv_voltage_code_q   <= VCODE_DEFAULT;
            conv_thermal_derate_q <= 1'b0;
            irq_en_q              <= 6'h00;
        end else if (mode_change && (fixed_mode || forced_norm)) begin
            conv_onoff_ctrl_q     <= ONOFF_DEFAULT;
            conv_voltage_code_q   <= VCODE_DEFAULT;
            conv_thermal_derate_q <= 1'b0;
            if (opmode == OPM_FAIL_SAFE || opmode == OPM_OFF || forced_norm) begin
                irq_en_q[IRQ_EN_CONV_BIT] <= 1'b0;
            end
        end else if (mode_change && opmode == OPM_SLEEP) begin
            conv_voltage_code_q <= VCODE_DEFAULT;
        end else begin
            if (wr_ctrl) begin
                conv_onoff_ctrl_q     <= reg_wdata[1:0];
                conv_thermal_derate_q <= reg_wdata[CTRL_DERATE_BIT];
            end
            if (wr_volt) begin
                conv_voltage_code_q <= reg_wdata[3:0];
            end
            if (wr_en) begin
                irq_en_q <= reg_wdata[5:0] & IRQ_EN_WMASK[5:0];
            end
        end
    end

    // status flag and pending flag; a change beats a clear
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            conv_status_flag_q     <= 1'b0;
            conv_status_irq_flag_q <= 1'b0;
        end else if (mode_change && (opmode == OPM_OFF || opmode == OPM_FAIL_SAFE ||
                                     forced_norm)) begin
            conv_status_flag_q     <= 1'b0;
            conv_status_irq_flag_q <= 1'b0;
        end else begin
            conv_status_flag_q <= status_now;
            if (status_chg) begin
                conv_status_irq_flag_q <= 1'b1;
            end else if (stat_clr) begin
                conv_status_irq_flag_q <= 1'b0;
            end
        end
    end

    // pass-through sequencing
    assign dwell_if.start = (pt_q == PT_SETTLE) && !out_above_set;
    assign entry_if.start = (pt_q == PT_SWITCH) && conv_run && pt_enter_ok &&
                            dwell_if.expired;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pt_q <= PT_SWITCH;
        end else begin
            case (pt_q)
                PT_SWITCH: if (entry_if.start) pt_q <= PT_RAMP;
                PT_RAMP: begin
                    if (pt_ramp_exit) begin
                        pt_q <= PT_SETTLE;
                    end else if (duty_q == 6'(PWM_PERIOD_CYC - 1) && entry_if.expired) begin
                        pt_q <= PT_HOLD;
                    end
                end
                PT_HOLD:   if (pt_exit) pt_q <= PT_SETTLE;
                PT_SETTLE: if (!out_above_set) pt_q <= PT_SWITCH;
                default:   pt_q <= PT_SWITCH;
            endcase
        end
    end

    // pwm, bootstrap slot, duty and soft-start
    wire pwm_wrap = (pwm_q == 6'(PWM_PERIOD_CYC - 1));
    wire boot_end = boot_slot_q && (pwm_q == 6'(BOOT_SLOT_CYC - 1));
    wire ramp_tick = (ramp_div_q == 8'(RAMP_STEP_CYC - 1));
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pwm_q <= 6'h00;
            period_cnt_q <= 5'h00;
            boot_slot_q <= 1'b0;
            ramp_div_q <= 8'h00;
        end else begin
            ramp_div_q <= ramp_tick ? 8'h00 : ramp_div_q + 8'h01;
            if (boot_end) begin
                pwm_q <= 6'h00;
                boot_slot_q <= 1'b0;
            end else begin
                pwm_q <= pwm_wrap ? 6'h00 : pwm_q + 6'h01;
            end
            if (pwm_wrap && !boot_slot_q) begin
                period_cnt_q <= period_cnt_q + 5'h01;
                // slot after each 32nd period in switching; in hold only if boot_low at the 32nd period
                if (pt_q == PT_HOLD) begin
                    boot_slot_q <= boot_low && (period_cnt_q == 5'(BOOT_EVERY_N - 1));
                end else begin
                    boot_slot_q <= (period_cnt_q == 5'(BOOT_EVERY_N - 1));
                end
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ss_limit_q <= 6'h00;
            duty_q     <= 6'h00;
        end else if (!conv_run) begin
            ss_limit_q <= 6'h00;
            duty_q     <= 6'h00;
        end else begin
            if (ramp_tick && ss_limit_q < 6'(PWM_PERIOD_CYC - SOFTSTART_STEP)) begin
                ss_limit_q <= ss_limit_q + 6'(SOFTSTART_STEP);
            end
            if (pt_q == PT_RAMP && ramp_tick && duty_q != 6'(PWM_PERIOD_CYC - 1)) begin
                duty_q <= duty_q + 6'h01;
            end else if (pt_q == PT_SWITCH) begin
                duty_q <= ss_limit_q >> 1;
            end
        end
    end

    // switch pattern
    wire [3:0] code_eff = (conv_thermal_derate_q && overtemp_warn) ? VCODE_FLOOR
                                                                   : conv_voltage_code_q;
    wire       pwm_hi   = pwm_q < duty_q;
    sw_kind_e  kind;
    assign kind = in_near_out ? SW_AUTO : (in_above_out ? SW_BUCK : SW_BOOST);
    logic [3:0] sw_d;
    always_comb begin
        sw_d = 4'h0;
        if (!conv_run || pt_q == PT_SETTLE) begin
            sw_d = 4'h0;
        end else if (boot_slot_q) begin
            sw_d = 4'b1010;
        end else if (pt_q == PT_HOLD) begin
            sw_d = 4'b0101;
        end else begin
            case (kind)
                SW_BUCK:  sw_d = {1'b0, 1'b1, !pwm_hi, pwm_hi};
                SW_BOOST: sw_d = {!pwm_hi, pwm_hi, 1'b0, 1'b1};
                SW_AUTO:  sw_d = {pwm_hi, !pwm_hi, !pwm_hi, pwm_hi};
                default:  sw_d = 4'h0;
            endcase
        end
    end

    // sw_d bit order {s4, s3, s2, s1}; boot slot closes s2 and s4 to ground
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            {s4_q, s3_q, s2_q, s1_q} <= 4'h0;
            on_q <= 1'b0;
            pt_out_q <= 1'b0;
            irq_q <= 1'b0;
            rdata_q <= 8'h00;
        end else begin
            {s4_q, s3_q, s2_q, s1_q} <= sw_d;
            on_q <= conv_run;
            pt_out_q <= (pt_q == PT_HOLD);
            irq_q <= conv_status_irq_flag_q && irq_en_q[IRQ_EN_CONV_BIT];
            if (reg_rd) rdata_q <= rd_mux;
        end
    end

    assign sw_s1 = s1_q;
    assign sw_s2 = s2_q;
    assign sw_s3 = s3_q;
    assign sw_s4 = s4_q;
    assign conv_on = on_q;
    assign passthru_active = pt_out_q;
    assign conv_voltage_code = code_eff_q;
    assign conv_thermal_derate = conv_thermal_derate_q;
    assign conv_status_irq = irq_q;
    assign reg_rdata = rdata_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) code_eff_q <= VCODE_DEFAULT;
        else code_eff_q <= code_eff;
    end
endmodule
`default_nettype wire

// File: rtl/conv_dwell_timer.sv
// Purpose: restartable down counter for dwell and entry times
// Assumes: start restarts the count
// Notes:   expired holds until the next start
`timescale 1ns/100ps
`default_nettype none
module conv_dwell_timer #(
    parameter int COUNT = 2500
) (
    input  wire logic   clk,
    input  wire logic   rst,
    conv_timer_if.timer tif
);
    logic [31:0] cnt_q;
    logic        exp_q;
    assign tif.expired = exp_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_q <= 32'h0;
            exp_q <= 1'b1;
        end else if (tif.start) begin
            cnt_q <= 32'(COUNT - 1);
            exp_q <= 1'b0;
        end else if (cnt_q != 32'h0) begin
            cnt_q <= cnt_q - 32'h1;
        end else begin
            exp_q <= 1'b1;
        end
    end
endmodule
`default_nettype wire

// File: rtl/conv_pkg.sv
// Purpose: shared constants and types for the converter control block
// Assumes: one 250 MHz clock
// Notes:   register offsets are byte addresses on the register port
package conv_pkg;
    localparam logic [7:0] SUPPLY_IRQ_EN_ADDR  = 8'h1c;
    localparam logic [7:0] CONV_CTRL_ADDR      = 8'h19;
    localparam logic [7:0] CONV_VOLT_ADDR      = 8'h1a;
    localparam logic [7:0] SUPPLY_IRQ_STAT_ADDR = 8'h62;

    localparam int IRQ_EN_CONV_BIT   = 5;
    localparam int IRQ_EN_BATT_O_BIT = 4;
    localparam int IRQ_EN_BATT_U_BIT = 3;
    localparam int IRQ_EN_EXT_O_BIT  = 2;
    localparam int IRQ_EN_EXT_U_BIT  = 1;
    localparam int IRQ_EN_MAIN_U_BIT = 0;
    localparam logic [7:0] IRQ_EN_WMASK = 8'h3f;
    localparam int CTRL_DERATE_BIT = 3;

    localparam logic [1:0] ONOFF_DEFAULT   = 2'h0;
    localparam logic [1:0] ONOFF_PASSTHRU  = 2'h3;
    localparam logic [3:0] VCODE_DEFAULT   = 4'h5;
    localparam logic [3:0] VCODE_FLOOR     = 4'h0;

    localparam int PWM_PERIOD_CYC   = 64;
    localparam int BOOT_EVERY_N     = 32;
    localparam int BOOT_SLOT_CYC    = PWM_PERIOD_CYC / 4;
    localparam int SOFTSTART_STEP   = 4;
    localparam int RAMP_STEP_CYC    = 8;

    localparam int DWELL_TIME_US    = 10;
    localparam int ENTRY_TIME_US    = 10;
    localparam int CLK_MHZ          = 250;
    localparam int DWELL_CYC        = DWELL_TIME_US * CLK_MHZ;
    localparam int ENTRY_CYC        = ENTRY_TIME_US * CLK_MHZ;

    typedef enum logic [2:0] {
        OPM_OFF, OPM_FORCED_NORMAL, OPM_STANDBY, OPM_NORMAL,
        OPM_SLEEP, OPM_RESET, OPM_OVERLOAD, OPM_FAIL_SAFE
    } opmode_e;

    typedef enum logic [1:0] {SW_BUCK, SW_BOOST, SW_AUTO} sw_kind_e;
endpackage

// File: rtl/conv_timer_if.sv
// Purpose: start/expiry pair between the control and its timer
// Assumes: single clock domain
// Notes:   start is a one-cycle pulse
`timescale 1ns/100ps
`default_nettype none
interface conv_timer_if;
    logic start;
    logic expired;
    modport ctrl  (output start, input expired);
    modport timer (input start, output expired);
endinterface
`default_nettype wire

// File: tb/conv_ctrl_sva.sv
// Purpose: concurrent checks on the converter control ports
// Assumes: one clock, rst asynchronous active high
// Notes:   dwell and entry counts come in from the bound instance
`timescale 1ns/100ps
`default_nettype none
module conv_ctrl_sva
    import conv_pkg::*;
#(
    parameter int DWELL_COUNT = 20,
    parameter int ENTRY_COUNT = 20
) (
    input wire logic              clk,
    input wire logic              rst,
    input wire conv_pkg::opmode_e opmode,
    input wire logic              reg_wr,
    input wire logic              reg_rd,
    input wire logic [7:0]        reg_addr,
    input wire logic [7:0]        reg_wdata,
    input wire logic [7:0]        reg_rdata,
    input wire logic              in_under,
    input wire logic              in_over,
    input wire logic              overtemp_warn,
    input wire logic              overcurrent,
    input wire logic              sw_s1,
    input wire logic              sw_s2,
    input wire logic              sw_s3,
    input wire logic              sw_s4,
    input wire logic              conv_on,
    input wire logic              passthru_active,
    input wire logic [3:0]        conv_voltage_code,
    input wire logic              conv_thermal_derate
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // cycles since pass-through last held; saturates so long runs stay quiet
    logic [15:0] gap_q;
    logic [15:0] gap_d;
    wire logic   grounded = sw_s2 && sw_s4;
    assign gap_d = passthru_active ? 16'h0000 : gap_q + 16'(gap_q != 16'hffff);
    always_ff @(posedge clk or posedge rst) begin
        if (rst) gap_q <= 16'(DWELL_COUNT);
        else gap_q <= gap_d;
    end
    a_pt_switches: assert property (passthru_active |->
        (sw_s1 && sw_s3 && !grounded) || (!sw_s1 && !sw_s3 && grounded))
        else $error("pass-through switch pattern wrong");
    a_pt_entry_ok: assert property ($rose(passthru_active) |-> $past(!in_under && !in_over))
        else $error("pass-through entered with input fault");
    a_pt_exit_cause: assert property (passthru_active &&
        (in_under || in_over || overtemp_warn || overcurrent) |-> ##[1:4] !passthru_active)
        else $error("pass-through not left on fault");
    a_dwell_gap: assert property ($rose(passthru_active) |->
        gap_q >= 16'(DWELL_COUNT + ENTRY_COUNT))
        else $error("pass-through re-entered too early");
    a_irq_en_rw: assert property ((reg_wr && reg_addr == SUPPLY_IRQ_EN_ADDR &&
        opmode == OPM_NORMAL && $stable(opmode)) ##2 (reg_rd && reg_addr == SUPPLY_IRQ_EN_ADDR
        && opmode == OPM_NORMAL) |=> reg_rdata == ($past(reg_wdata, 3) & IRQ_EN_WMASK))
        else $error("irq enable readback wrong");
    a_resv_zero: assert property (reg_rd && reg_addr == SUPPLY_IRQ_EN_ADDR
        |=> reg_rdata[7:6] == 2'b00)
        else $error("reserved enable bits not zero");
    a_fn_reads_zero: assert property (reg_rd && opmode == OPM_FORCED_NORMAL
        |=> reg_rdata == 8'h00)
        else $error("forced-normal read not zero");
    a_forced_dflt: assert property (opmode inside {OPM_RESET, OPM_OVERLOAD, OPM_FAIL_SAFE}
        && $stable(opmode) |=> conv_on == ($past(opmode) != OPM_OVERLOAD)
        && conv_voltage_code == VCODE_DEFAULT && !conv_thermal_derate)
        else $error("forced mode defaults wrong");
    a_off_state: assert property (opmode == OPM_OFF && $stable(opmode) |=> !conv_on
        && conv_voltage_code == VCODE_DEFAULT && !conv_thermal_derate && !sw_s1 && !sw_s3)
        else $error("off state not off");
    a_boot_slot: assert property ($rose(grounded) && !passthru_active
        |-> grounded[*8] ##1 grounded[*8] ##1 !grounded)
        else $error("bootstrap slot length wrong");
    c_pt_enter: cover property ($rose(passthru_active));
    c_pt_leave: cover property ($fell(passthru_active));
    c_boot: cover property ($rose(grounded));
    c_fn_read: cover property (reg_rd && opmode == OPM_FORCED_NORMAL);
endmodule
bind conv_ctrl conv_ctrl_sva #(.DWELL_COUNT(DWELL_COUNT), .ENTRY_COUNT(ENTRY_COUNT)) i_sva (
    .clk(clk), .rst(rst), .opmode(opmode), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .in_under(in_under), .in_over(in_over), .overtemp_warn(overtemp_warn),
    .overcurrent(overcurrent), .sw_s1(sw_s1), .sw_s2(sw_s2), .sw_s3(sw_s3), .sw_s4(sw_s4),
    .conv_on(conv_on), .passthru_active(passthru_active),
    .conv_voltage_code(conv_voltage_code), .conv_thermal_derate(conv_thermal_derate));
`default_nettype wire

// File: tb/conv_ctrl_test.sv
// Purpose: self-checking bench for the converter control block
// Assumes: inputs change on the falling edge
// Notes:   dwell and entry counts shortened to 20 cycles
`timescale 1ns/100ps
`default_nettype none
module conv_ctrl_test;
    import conv_pkg::*;
    typedef struct {opmode_e m; logic [7:0] ctrl; logic [7:0] irq; logic on;} row_s;
    row_s rows [4] = '{'{OPM_RESET, 8'h00, 8'h3f, 1'b1}, '{OPM_OVERLOAD, 8'h00, 8'h3f, 1'b0},
                       '{OPM_FAIL_SAFE, 8'h00, 8'h1f, 1'b1}, '{OPM_SLEEP, 8'h0b, 8'h3f, 1'b1}};
    logic [7:0] pat [4] = '{8'h3f, 8'h2a, 8'h15, 8'h00};
    logic clk = 1'b0, rst = 1'b1, in_above_out = 1'b1, in_near_out = 1'b0, in_under = 1'b0;
    logic in_over = 1'b0, overtemp_warn = 1'b0, overcurrent = 1'b0, out_in_window = 1'b1;
    logic out_above_set = 1'b0, boot_low = 1'b0;
    opmode_e opmode = OPM_OFF;
    logic reg_wr, reg_rd, sw_s1, sw_s2, sw_s3, sw_s4, conv_on, passthru_active;
    logic conv_thermal_derate, conv_status_irq;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic [3:0] conv_voltage_code;
    wire logic [3:0] sw = {sw_s4, sw_s3, sw_s2, sw_s1};
    int n_fail = 0, n_compared = 0, cyc_n = 0, gnd = 0;
    int hi [4];
    conv_ctrl #(.DWELL_COUNT(20), .ENTRY_COUNT(20)) i_dut (
        .clk(clk), .rst(rst), .opmode(opmode), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .in_above_out(in_above_out), .in_near_out(in_near_out), .in_under(in_under),
        .in_over(in_over), .overtemp_warn(overtemp_warn), .overcurrent(overcurrent),
        .out_in_window(out_in_window), .out_above_set(out_above_set), .boot_low(boot_low),
        .sw_s1(sw_s1), .sw_s2(sw_s2), .sw_s3(sw_s3), .sw_s4(sw_s4), .conv_on(conv_on),
        .passthru_active(passthru_active), .conv_voltage_code(conv_voltage_code),
        .conv_thermal_derate(conv_thermal_derate), .conv_status_irq(conv_status_irq));
    conv_mcu_model i_mcu (.clk(clk), .reg_rdata(reg_rdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata));
    initial begin
        forever #2 clk = ~clk;
    end
    task automatic finish_test;
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cyc_n++;
        if (cyc_n == 40000) begin
            n_fail++;
            finish_test();
        end
    end
    task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic cyc(int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic rdchk(string what, logic [7:0] a, logic [7:0] exp);
        logic [7:0] d;
        i_mcu.rd(a, d);
        check(what, d, exp);
    endtask
    task automatic wait_pt(logic lvl, int lim);
        for (int k = 0; k < lim && passthru_active !== lvl; k++) cyc(1);
    endtask
    task automatic watch(int n);
        hi = '{0, 0, 0, 0};
        gnd = 0;
        repeat (n) begin
            cyc(1);
            gnd += int'(sw_s2 === 1'b1 && sw_s4 === 1'b1);
            foreach (hi[j]) hi[j] += int'(sw[j] === 1'b1);
        end
    endtask
    initial begin
        repeat (16) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        cyc(2);
        check("off code", 8'(conv_voltage_code), 8'h05);
        check("off on", 8'(conv_on), 8'h00);
        opmode = OPM_NORMAL;
        cyc(4);
        foreach (pat[i]) begin
            i_mcu.wr(SUPPLY_IRQ_EN_ADDR, pat[i]);
            rdchk("irq en", SUPPLY_IRQ_EN_ADDR, pat[i]);
        end
        rdchk("unmapped", 8'h55, 8'h00);
        foreach (rows[i]) begin
            opmode = OPM_NORMAL;
            cyc(4);
            i_mcu.wr(CONV_CTRL_ADDR, 8'h0b);
            i_mcu.wr(CONV_VOLT_ADDR, 8'h0a);
            i_mcu.wr(SUPPLY_IRQ_EN_ADDR, 8'h3f);
            opmode = rows[i].m;
            cyc(4);
            rdchk("ctrl", CONV_CTRL_ADDR, rows[i].ctrl);
            rdchk("vcode", CONV_VOLT_ADDR, 8'h05);
            rdchk("irq en", SUPPLY_IRQ_EN_ADDR, rows[i].irq);
            check("on", 8'(conv_on), 8'(rows[i].on));
        end
        // slow master here: spacing between requests must not matter
        i_mcu.gap = 2;
        opmode = OPM_FORCED_NORMAL;
        cyc(4);
        i_mcu.wr(SUPPLY_IRQ_EN_ADDR, 8'h3f);
        rdchk("fn irq en", SUPPLY_IRQ_EN_ADDR, 8'h00);
        rdchk("fn ctrl", CONV_CTRL_ADDR, 8'h00);
        check("fn on", 8'(conv_on), 8'h01);
        i_mcu.gap = 0;
        opmode = OPM_NORMAL;
        cyc(4);
        i_mcu.wr(CONV_CTRL_ADDR, 8'h00);
        cyc(4);
        check("normal on", 8'(conv_on), 8'h01);
        opmode = OPM_SLEEP;
        cyc(4);
        check("sleep off", 8'(conv_on), 8'h00);
        i_mcu.wr(CONV_CTRL_ADDR, 8'h01);
        cyc(4);
        check("sleep on", 8'(conv_on), 8'h01);
        opmode = OPM_NORMAL;
        cyc(300);
        for (int k = 0; k < 2200 && !(sw_s2 && sw_s4); k++) cyc(1);
        for (int k = 0; k < 20 && (sw_s2 && sw_s4); k++) cyc(1);
        watch(2064);
        check("boot cycles", 8'(gnd), 8'd16);
        check("buck s3", 8'(hi[2] + gnd == 2064), 8'h01);
        check("buck s1", 8'(hi[0] > 0 && hi[0] < 2064), 8'h01);
        in_above_out = 1'b0;
        cyc(64);
        watch(128);
        check("boost s1", 8'(hi[0] + gnd == 128), 8'h01);
        check("boost s3", 8'(hi[2] > 0 && hi[2] < 128), 8'h01);
        in_near_out = 1'b1;
        cyc(64);
        watch(128);
        foreach (hi[j]) check("auto sw", 8'(hi[j] > 0 && hi[j] < 128), 8'h01);
        in_near_out = 1'b0;
        in_above_out = 1'b1;
        in_under = 1'b1;
        i_mcu.wr(CONV_CTRL_ADDR, 8'h03);
        cyc(800);
        check("pt blocked", 8'(passthru_active), 8'h00);
        in_under = 1'b0;
        cyc(100);
        check("pt ramping", 8'(passthru_active), 8'h00);
        for (int c = 0; c < 4; c++) begin
            wait_pt(1'b1, 3000);
            check("pt on", 8'(passthru_active), 8'h01);
            {in_under, in_over, overtemp_warn, overcurrent} = 4'b1000 >> c;
            out_above_set = 1'b1;
            cyc(4);
            check("pt off", 8'(passthru_active), 8'h00);
            check("settle open", 8'(sw), 8'h00);
            out_above_set = 1'b0;
            if (c == 3) begin
                wait_pt(1'b1, 3000);
                check("pt retry", 8'(passthru_active), 8'h01);
                wait_pt(1'b0, 8);
                check("pt refail", 8'(passthru_active), 8'h00);
            end
            {in_under, in_over, overtemp_warn, overcurrent} = 4'b0000;
        end
        i_mcu.wr(CONV_CTRL_ADDR, 8'h00);
        cyc(40);
        i_mcu.wr(SUPPLY_IRQ_STAT_ADDR, 8'h20);
        i_mcu.wr(SUPPLY_IRQ_EN_ADDR, 8'h20);
        out_in_window = 1'b0;
        cyc(8);
        check("status irq", 8'(conv_status_irq), 8'h01);
        i_mcu.wr(SUPPLY_IRQ_STAT_ADDR, 8'h20);
        cyc(2);
        check("irq cleared", 8'(conv_status_irq), 8'h00);
        i_mcu.wr(CONV_CTRL_ADDR, 8'h08);
        overtemp_warn = 1'b1;
        cyc(4);
        check("derate bit", 8'(conv_thermal_derate), 8'h01);
        check("derate code", 8'(conv_voltage_code), 8'h00);
        overtemp_warn = 1'b0;
        cyc(4);
        check("code back", 8'(conv_voltage_code), 8'h05);
        finish_test();
    end
endmodule
`default_nettype wire

// File: tb/conv_mcu_model.sv
// Purpose: microcontroller side of the register port
// Assumes: requests launched on the falling edge
// Notes:   released lines show the inverse of their last value
`timescale 1ns/100ps
`default_nettype none
module conv_mcu_model
    import conv_pkg::*;
(
    input  wire logic       clk,
    input  wire logic [7:0] reg_rdata,
    output logic            reg_wr,
    output logic            reg_rd,
    output logic      [7:0] reg_addr,
    output logic      [7:0] reg_wdata
);
    int gap = 0;
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
    end
    task automatic wr(logic [7:0] a, logic [7:0] d);
        repeat (gap + 1) @(negedge clk);
        reg_addr = a;
        reg_wdata = (a == SUPPLY_IRQ_EN_ADDR) ? (d & IRQ_EN_WMASK) : d;
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
        reg_addr = ~reg_addr;
        reg_wdata = ~reg_wdata;
    endtask
    task automatic rd(logic [7:0] a, output logic [7:0] d);
        repeat (gap + 1) @(negedge clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk);
        reg_rd = 1'b0;
        reg_addr = ~reg_addr;
        @(negedge clk);
        d = reg_rdata;
    endtask
endmodule
`default_nettype wire
